/* File: common/mcd_pkg.sv */
// Package for the measurement command decoder: command codes, memory
// layout, reply sizes and status byte fields.
// Assumes both link ends and the bench import nothing and use mcd_pkg::name.
package mcd_pkg;

    typedef enum logic [1:0] {
        MCD_MODE_POWERUP,
        MCD_MODE_SLEEP,
        MCD_MODE_CMD,
        MCD_MODE_CYCLIC
    } mcd_mode_t;

    localparam logic [7:0] MCD_CMD_READ_LAST   = 8'h1F;
    localparam logic [7:0] MCD_CMD_WRITE_FIRST = 8'h20;
    localparam logic [7:0] MCD_CMD_WRITE_LAST  = 8'h3C;
    localparam logic [7:0] MCD_CMD_CHECKSUM    = 8'h90;
    localparam logic [7:0] MCD_CMD_RAW_SENSOR  = 8'hA2;
    localparam logic [7:0] MCD_CMD_RAW_USER    = 8'hA3;
    localparam logic [7:0] MCD_CMD_RAW_TEMP    = 8'hA6;
    localparam logic [7:0] MCD_CMD_SLEEP       = 8'hA8;
    localparam logic [7:0] MCD_CMD_ENTER_CMD   = 8'hA9;
    localparam logic [7:0] MCD_CMD_MEASURE     = 8'hAA;

    // Memory words and the configuration slots inside it
    localparam int         MCD_MEM_WORDS       = 32;
    localparam logic [4:0] MCD_ADDR_SENSOR_CFG = 5'h03;
    localparam logic [4:0] MCD_ADDR_TEMP_CFG   = 5'h04;
    localparam logic [4:0] MCD_ADDR_SCALE_CFG  = 5'h05;
    localparam logic [4:0] MCD_ADDR_CHECKSUM   = 5'h1C;
    localparam logic [15:0] MCD_MEM_RESET      = 16'h0000;

    // Measurement kinds in full-measure order
    localparam logic [1:0] MCD_KIND_SENSOR_ZERO = 2'h0;
    localparam logic [1:0] MCD_KIND_SENSOR      = 2'h1;
    localparam logic [1:0] MCD_KIND_TEMP_ZERO   = 2'h2;
    localparam logic [1:0] MCD_KIND_TEMP        = 2'h3;

    // Reply lengths in bytes, status byte not counted
    localparam logic [2:0] MCD_LEN_NONE = 3'h0;
    localparam logic [2:0] MCD_LEN_WORD = 3'h2;
    localparam logic [2:0] MCD_LEN_RAW  = 3'h3;
    localparam logic [2:0] MCD_LEN_FULL = 3'h6;

    localparam int         MCD_ST_POWER = 6;
    localparam int         MCD_ST_BUSY  = 5;
    localparam logic [1:0] MCD_ST_MODE_NORMAL = 2'h0;
    localparam logic [1:0] MCD_ST_MODE_CMD    = 2'h1;

    function automatic logic mcd_is_write(input logic [7:0] cmd);
        return cmd >= MCD_CMD_WRITE_FIRST && cmd <= MCD_CMD_WRITE_LAST;
    endfunction

    // Command availability per operating mode
    function automatic logic mcd_cmd_ok(input mcd_mode_t mode, input logic [7:0] cmd);
        logic base;
        base = cmd <= MCD_CMD_READ_LAST || mcd_is_write(cmd) || cmd == MCD_CMD_CHECKSUM
            || cmd == MCD_CMD_RAW_SENSOR || cmd == MCD_CMD_RAW_USER
            || cmd == MCD_CMD_RAW_TEMP || cmd == MCD_CMD_MEASURE;
        case (mode)
            MCD_MODE_POWERUP: return cmd == MCD_CMD_ENTER_CMD;
            MCD_MODE_SLEEP:   return base;
            MCD_MODE_CMD:     return base || cmd == MCD_CMD_SLEEP || cmd == MCD_CMD_ENTER_CMD;
            MCD_MODE_CYCLIC:  return cmd == MCD_CMD_SLEEP;
            default:          return 1'b0;
        endcase
    endfunction

    // Half of signal minus its auto-zero sample, LSB aligned
    function automatic logic [23:0] mcd_raw_half(input logic [23:0] sig, input logic [23:0] zero);
        logic signed [24:0] diff;
        diff = $signed({sig[23], sig}) - $signed({zero[23], zero});
        return diff[24:1];
    endfunction

endpackage

/* File: common/mcd_link_if.sv */
// Link between the host controller and the command decoder, at the level
// of whole commands and replies; the serial framing lies outside.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface mcd_link_if;
    logic        req_valid;
    logic [7:0]  req_cmd;
    logic [15:0] req_data;
    logic        ack_valid;
    logic        ack_ok;
    logic        rsp_valid;
    logic [47:0] rsp_data;
    logic [2:0]  rsp_len;
    logic [7:0]  status;

    modport dev (
        input  req_valid, req_cmd, req_data,
        output ack_valid, ack_ok, rsp_valid, rsp_data, rsp_len, status
    );
    modport host (
        output req_valid, req_cmd, req_data,
        input  ack_valid, ack_ok, rsp_valid, rsp_data, rsp_len, status
    );
endinterface

/* File: design/mcd_device.sv */
// Device end: decodes commands, runs memory access, checksum and
// measurement sequences, and formats results into the reply word.
// Assumes an external converter and correction unit with start/done handshakes.
`timescale 1ns/10ps
module mcd_device (
    input  wire logic        clock,
    input  wire logic        resetn,
    mcd_link_if.dev          link,
    output logic             meas_start,
    output logic [1:0]       meas_kind,
    output logic             meas_swap,
    output logic [15:0]      meas_cfg,
    output logic [15:0]      meas_scale,
    input  wire logic        meas_done,
    input  wire logic [23:0] meas_value,
    output logic             corr_start,
    output logic [23:0]      corr_sensor_raw,
    output logic [23:0]      corr_temp_raw,
    input  wire logic        corr_done,
    input  wire logic [23:0] corr_sensor,
    input  wire logic [23:0] corr_temp,
    input  wire logic        nvm_locked,
    input  wire logic        cyclic_enter
);

    typedef enum logic [2:0] {
        MCD_S_IDLE,
        MCD_S_MEAS_GO,
        MCD_S_MEAS_WAIT,
        MCD_S_CORR_GO,
        MCD_S_CORR_WAIT,
        MCD_S_SUM,
        MCD_S_REPLY
    } mcd_state_t;

    typedef enum logic [1:0] {
        MCD_OP_RAW_SENSOR,
        MCD_OP_RAW_TEMP,
        MCD_OP_FULL
    } mcd_op_t;

    mcd_pkg::mcd_mode_t mode_reg;
    mcd_state_t         state_reg;
    mcd_op_t            op_reg;
    logic [15:0]        mem [mcd_pkg::MCD_MEM_WORDS];
    logic [1:0]         step_reg;
    logic [1:0]         last_reg;
    logic [15:0]        sens_cfg_reg;
    logic [15:0]        temp_cfg_reg;
    logic [23:0]        sample_reg [4];
    logic [15:0]        sum_reg;
    logic [4:0]         sum_idx_reg;
    logic               accept;
    logic               is_write;
    logic [4:0]         write_addr;

    assign is_write   = mcd_pkg::mcd_is_write(link.req_cmd);
    assign write_addr = 5'(link.req_cmd - mcd_pkg::MCD_CMD_WRITE_FIRST);
    // Refused requests leave mode, memory and results alone
    assign accept = link.req_valid && state_reg == MCD_S_IDLE
        && mcd_pkg::mcd_cmd_ok(mode_reg, link.req_cmd)
        && !(is_write && nvm_locked);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.ack_valid <= 1'b0;
            link.ack_ok    <= 1'b0;
        end else begin
            link.ack_valid <= link.req_valid;
            link.ack_ok    <= accept;
        end
    end

    // Power-up state only leaves on command-mode entry
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= mcd_pkg::MCD_MODE_POWERUP;
        end else if (accept && link.req_cmd == mcd_pkg::MCD_CMD_SLEEP) begin
            mode_reg <= mcd_pkg::MCD_MODE_SLEEP;
        end else if (accept && link.req_cmd == mcd_pkg::MCD_CMD_ENTER_CMD) begin
            mode_reg <= mcd_pkg::MCD_MODE_CMD;
        end else if (cyclic_enter && state_reg == MCD_S_IDLE && !link.req_valid
                     && mode_reg != mcd_pkg::MCD_MODE_POWERUP) begin
            mode_reg <= mcd_pkg::MCD_MODE_CYCLIC;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            link.status <= 8'h00;
        end else begin
            link.status <= 8'h00;
            link.status[mcd_pkg::MCD_ST_POWER] <= 1'b1;
            link.status[mcd_pkg::MCD_ST_BUSY]  <= state_reg != MCD_S_IDLE;
            link.status[4:3] <= mode_reg == mcd_pkg::MCD_MODE_CMD
                ? mcd_pkg::MCD_ST_MODE_CMD : mcd_pkg::MCD_ST_MODE_NORMAL;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < mcd_pkg::MCD_MEM_WORDS; i++) begin
                mem[i] <= mcd_pkg::MCD_MEM_RESET;
            end
        end else if (accept && is_write) begin
            mem[write_addr] <= link.req_data;
        end else if (state_reg == MCD_S_SUM && sum_idx_reg == mcd_pkg::MCD_ADDR_CHECKSUM) begin
            mem[mcd_pkg::MCD_ADDR_CHECKSUM] <= sum_reg;
        end
    end

    // Shadow setup words latched at command start
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sens_cfg_reg <= 16'h0000;
            temp_cfg_reg <= 16'h0000;
            meas_scale   <= 16'h0000;
        end else if (accept) begin
            case (link.req_cmd)
                mcd_pkg::MCD_CMD_RAW_SENSOR: begin
                    sens_cfg_reg <= mem[mcd_pkg::MCD_ADDR_SENSOR_CFG];
                end
                mcd_pkg::MCD_CMD_RAW_USER: begin
                    sens_cfg_reg <= link.req_data;
                end
                mcd_pkg::MCD_CMD_RAW_TEMP, mcd_pkg::MCD_CMD_MEASURE: begin
                    sens_cfg_reg <= mem[mcd_pkg::MCD_ADDR_SENSOR_CFG];
                    temp_cfg_reg <= mem[mcd_pkg::MCD_ADDR_TEMP_CFG];
                    meas_scale   <= mem[mcd_pkg::MCD_ADDR_SCALE_CFG];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg       <= MCD_S_IDLE;
            op_reg          <= MCD_OP_FULL;
            step_reg        <= 2'h0;
            last_reg        <= 2'h0;
            sum_reg         <= 16'h0000;
            sum_idx_reg     <= 5'h00;
            meas_start      <= 1'b0;
            meas_kind       <= 2'h0;
            meas_swap       <= 1'b0;
            meas_cfg        <= 16'h0000;
            corr_start      <= 1'b0;
            corr_sensor_raw <= 24'h000000;
            corr_temp_raw   <= 24'h000000;
            link.rsp_valid  <= 1'b0;
            link.rsp_data   <= 48'h000000000000;
            link.rsp_len    <= mcd_pkg::MCD_LEN_NONE;
            for (int i = 0; i < 4; i++) begin
                sample_reg[i] <= 24'h000000;
            end
        end else begin
            meas_start     <= 1'b0;
            corr_start     <= 1'b0;
            link.rsp_valid <= 1'b0;
            case (state_reg)
                MCD_S_IDLE: begin
                    if (accept) begin
                        state_reg     <= MCD_S_REPLY;
                        link.rsp_len  <= mcd_pkg::MCD_LEN_NONE;
                        link.rsp_data <= 48'h000000000000;
                        if (link.req_cmd <= mcd_pkg::MCD_CMD_READ_LAST) begin
                            link.rsp_data <= {32'h00000000, mem[link.req_cmd[4:0]]};
                            link.rsp_len  <= mcd_pkg::MCD_LEN_WORD;
                        end else if (link.req_cmd == mcd_pkg::MCD_CMD_CHECKSUM) begin
                            state_reg   <= MCD_S_SUM;
                            sum_reg     <= 16'h0000;
                            sum_idx_reg <= 5'h00;
                        end else if (link.req_cmd == mcd_pkg::MCD_CMD_RAW_SENSOR
                                  || link.req_cmd == mcd_pkg::MCD_CMD_RAW_USER) begin
                            state_reg <= MCD_S_MEAS_GO;
                            op_reg    <= MCD_OP_RAW_SENSOR;
                            step_reg  <= mcd_pkg::MCD_KIND_SENSOR_ZERO;
                            last_reg  <= mcd_pkg::MCD_KIND_SENSOR;
                        end else if (link.req_cmd == mcd_pkg::MCD_CMD_RAW_TEMP) begin
                            state_reg <= MCD_S_MEAS_GO;
                            op_reg    <= MCD_OP_RAW_TEMP;
                            step_reg  <= mcd_pkg::MCD_KIND_TEMP_ZERO;
                            last_reg  <= mcd_pkg::MCD_KIND_TEMP;
                        end else if (link.req_cmd == mcd_pkg::MCD_CMD_MEASURE) begin
                            state_reg <= MCD_S_MEAS_GO;
                            op_reg    <= MCD_OP_FULL;
                            step_reg  <= mcd_pkg::MCD_KIND_SENSOR_ZERO;
                            last_reg  <= mcd_pkg::MCD_KIND_TEMP;
                        end
                    end
                end
                MCD_S_MEAS_GO: begin
                    // Zero sample keeps the signal setup; only the swap flag and the kind differ
                    meas_start <= 1'b1;
                    meas_kind  <= step_reg;
                    meas_swap  <= !step_reg[0];
                    meas_cfg   <= step_reg[1] ? temp_cfg_reg : sens_cfg_reg;
                    state_reg  <= MCD_S_MEAS_WAIT;
                end
                MCD_S_MEAS_WAIT: begin
                    if (meas_done) begin
                        sample_reg[step_reg] <= meas_value;
                        if (step_reg != last_reg) begin
                            step_reg  <= 2'(step_reg + 2'h1);
                            state_reg <= MCD_S_MEAS_GO;
                        end else if (op_reg == MCD_OP_FULL) begin
                            corr_sensor_raw <= mcd_pkg::mcd_raw_half(
                                sample_reg[mcd_pkg::MCD_KIND_SENSOR],
                                sample_reg[mcd_pkg::MCD_KIND_SENSOR_ZERO]);
                            corr_temp_raw <= mcd_pkg::mcd_raw_half(meas_value,
                                sample_reg[mcd_pkg::MCD_KIND_TEMP_ZERO]);
                            state_reg <= MCD_S_CORR_GO;
                        end else begin
                            // Raw word sits at the low end
                            link.rsp_data <= {24'h000000, mcd_pkg::mcd_raw_half(meas_value,
                                sample_reg[{step_reg[1], 1'b0}])};
                            link.rsp_len  <= mcd_pkg::MCD_LEN_RAW;
                            state_reg     <= MCD_S_REPLY;
                        end
                    end
                end
                MCD_S_CORR_GO: begin
                    corr_start <= 1'b1;
                    state_reg  <= MCD_S_CORR_WAIT;
                end
                MCD_S_CORR_WAIT: begin
                    if (corr_done) begin
                        // Fractions passed whole, bit 23 weight one
                        link.rsp_data <= {corr_sensor, corr_temp};
                        link.rsp_len  <= mcd_pkg::MCD_LEN_FULL;
                        state_reg     <= MCD_S_REPLY;
                    end
                end
                MCD_S_SUM: begin
                    // Sum over all words below the checksum slot, one per cycle
                    if (sum_idx_reg == mcd_pkg::MCD_ADDR_CHECKSUM) begin
                        state_reg <= MCD_S_REPLY;
                    end else begin
                        sum_reg     <= 16'(sum_reg + mem[sum_idx_reg]);
                        sum_idx_reg <= 5'(sum_idx_reg + 5'h01);
                    end
                end
                MCD_S_REPLY: begin
                    link.rsp_valid <= 1'b1;
                    state_reg      <= MCD_S_IDLE;
                end
                default: begin
                    state_reg <= MCD_S_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: design/mcd_host.sv */
// Host end: sends command-mode entry after reset, then forwards user
// commands one at a time and returns the device's answer.
// Assumes the device end answers every request with one ack pulse.
`timescale 1ns/10ps
module mcd_host (
    input  wire logic        clock,
    input  wire logic        resetn,
    mcd_link_if.host         link,
    input  wire logic        cmd_go,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic [15:0] cmd_data,
    output logic             cmd_ready,
    output logic             done,
    output logic             done_ok,
    output logic [47:0]      result,
    output logic [2:0]       result_len,
    output logic [7:0]       dev_status
);

    typedef enum logic [2:0] {
        MCD_H_BOOT,
        MCD_H_BOOT_WAIT,
        MCD_H_IDLE,
        MCD_H_WAIT_ACK,
        MCD_H_WAIT_RSP
    } mcd_hstate_t;

    mcd_hstate_t state_reg;
    logic        boot_reg;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dev_status <= 8'h00;
        end else begin
            dev_status <= link.status;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg      <= MCD_H_BOOT;
            boot_reg       <= 1'b1;
            link.req_valid <= 1'b0;
            link.req_cmd   <= 8'h00;
            link.req_data  <= 16'h0000;
            cmd_ready      <= 1'b0;
            done           <= 1'b0;
            done_ok        <= 1'b0;
            result         <= 48'h000000000000;
            result_len     <= mcd_pkg::MCD_LEN_NONE;
        end else begin
            link.req_valid <= 1'b0;
            done           <= 1'b0;
            case (state_reg)
                MCD_H_BOOT: begin
                    // First command after power-up
                    link.req_valid <= 1'b1;
                    link.req_cmd   <= mcd_pkg::MCD_CMD_ENTER_CMD;
                    link.req_data  <= 16'h0000;
                    state_reg      <= MCD_H_WAIT_ACK;
                end
                MCD_H_IDLE: begin
                    if (cmd_go) begin
                        cmd_ready      <= 1'b0;
                        link.req_valid <= 1'b1;
                        link.req_cmd   <= cmd_byte;
                        // Stored-setup raw commands carry zero data
                        link.req_data  <= (cmd_byte == mcd_pkg::MCD_CMD_RAW_SENSOR
                            || cmd_byte == mcd_pkg::MCD_CMD_RAW_TEMP) ? 16'h0000 : cmd_data;
                        state_reg      <= MCD_H_WAIT_ACK;
                    end
                end
                MCD_H_WAIT_ACK: begin
                    if (link.ack_valid) begin
                        if (link.ack_ok) begin
                            state_reg <= MCD_H_WAIT_RSP;
                        end else if (boot_reg) begin
                            state_reg <= MCD_H_BOOT;
                        end else begin
                            done      <= 1'b1;
                            done_ok   <= 1'b0;
                            cmd_ready <= 1'b1;
                            state_reg <= MCD_H_IDLE;
                        end
                    end
                end
                MCD_H_WAIT_RSP: begin
                    if (link.rsp_valid) begin
                        boot_reg   <= 1'b0;
                        done       <= !boot_reg;
                        done_ok    <= 1'b1;
                        result     <= link.rsp_data;
                        result_len <= link.rsp_len;
                        cmd_ready  <= 1'b1;
                        state_reg  <= MCD_H_IDLE;
                    end
                end
                default: begin
                    state_reg <= MCD_H_IDLE;
                end
            endcase
        end
    end

endmodule

/* File: tb/mcd_link_assertions.sv */
// Checker on the link between host and device ends.
// Assumes the bench wires it beside the link, with the same clock and reset.
`timescale 1ns/10ps
module mcd_link_assertions (
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        req_valid,
    input wire logic [7:0]  req_cmd,
    input wire logic        ack_valid,
    input wire logic        ack_ok,
    input wire logic        rsp_valid,
    input wire logic [47:0] rsp_data,
    input wire logic [2:0]  rsp_len,
    input wire logic [7:0]  status
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    a_ack_follows: assert property (req_valid |=> ack_valid) else $error("ack late");
    a_reply_due: assert property (ack_valid && ack_ok |-> ##[1:200] rsp_valid)
        else $error("no reply");
    a_refused_quiet: assert property (ack_valid && !ack_ok |=> !rsp_valid)
        else $error("refused reply");
    a_power_bit: assert property (resetn && $past(resetn) |-> status[6])
        else $error("power");
    a_len_legal: assert property (rsp_valid |-> rsp_len inside {3'h0, 3'h2, 3'h3, 3'h6})
        else $error("bad length");
    a_read_width: assert property (rsp_valid && rsp_len == 3'h2
        |-> rsp_data[47:16] == 32'h0) else $error("read width");
    a_raw_lsb: assert property (rsp_valid && rsp_len == 3'h3
        |-> rsp_data[47:24] == 24'h0) else $error("raw align");
    a_mode_command: assert property (ack_valid && ack_ok && $past(req_cmd) == 8'hA9
        |=> status[4:3] == mcd_pkg::MCD_ST_MODE_CMD) else $error("command mode");
    a_mode_sleep: assert property (ack_valid && ack_ok && $past(req_cmd) == 8'hA8
        |=> status[4:3] == mcd_pkg::MCD_ST_MODE_NORMAL) else $error("sleep mode");
    c_refused: cover property (ack_valid && !ack_ok);
    c_measure: cover property (rsp_valid && rsp_len == 3'h6);
    c_checksum: cover property (req_valid && req_cmd == 8'h90);
endmodule

/* File: tb/test_measurement_command_decoder.sv */
// Bench joining both link ends, with a prompt converter and corrector.
// Assumes the package and link interface are compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module test_measurement_command_decoder;
    typedef struct packed {
        logic [7:0]  cmd;
        logic [15:0] data;
        logic        ok;
        logic [2:0]  len;
        logic [47:0] res;
        logic [7:0]  kinds;
    } mcd_row_t;
    logic        clock = 1'b0, resetn = 1'b0, cmd_go = 1'b0, nvm_locked = 1'b0;
    logic        cyclic_enter = 1'b0, meas_done = 1'b0, corr_done = 1'b0, swap_bad = 1'b0;
    logic        meas_start, meas_swap, corr_start, cmd_ready, done, done_ok;
    logic [1:0]  meas_kind;
    logic [2:0]  result_len;
    logic [7:0]  cmd_byte = 8'h00, kinds = 8'h00, dev_status;
    logic [15:0] cmd_data = 16'h0000;
    logic [15:0] meas_cfg, meas_scale, cfg_seen;
    logic [23:0] meas_value = 24'h0, corr_sensor = 24'h0, corr_temp = 24'h0;
    logic [23:0] corr_sensor_raw, corr_temp_raw;
    logic [47:0] result;
    int          n_errors = 0, n_checks = 0;
    mcd_row_t    rows [17] = '{
        '{8'h23, 16'h1234, 1'b1, 3'h0, 48'h0, 8'h00}, '{8'h03, 16'h0, 1'b1, 3'h2, 48'h1234, 8'h00},
        '{8'h3C, 16'hABCD, 1'b1, 3'h0, 48'h0, 8'h00}, '{8'h1C, 16'h0, 1'b1, 3'h2, 48'hABCD, 8'h00},
        '{8'h90, 16'h0, 1'b1, 3'h0, 48'h0, 8'h00}, '{8'h1C, 16'h0, 1'b1, 3'h2, 48'h1234, 8'h00},
        '{8'h24, 16'h0F0F, 1'b1, 3'h0, 48'h0, 8'h00}, '{8'h25, 16'h3C3C, 1'b1, 3'h0, 48'h0, 8'h00},
        '{8'hA3, 16'h5555, 1'b1, 3'h3, 48'h80, 8'h01}, '{8'hA2, 16'h0, 1'b1, 3'h3, 48'h80, 8'h01},
        '{8'hA6, 16'h0, 1'b1, 3'h3, 48'h200, 8'h0B},
        '{8'hAA, 16'h0, 1'b1, 3'h6, 48'hC00080400200, 8'h1B},
        '{8'hA8, 16'h0, 1'b1, 3'h0, 48'h0, 8'h00}, '{8'hA8, 16'h0, 1'b0, 3'h0, 48'h0, 8'h00},
        '{8'hA9, 16'h0, 1'b0, 3'h0, 48'h0, 8'h00}, '{8'hAB, 16'h0, 1'b0, 3'h0, 48'h0, 8'h00},
        '{8'h03, 16'h0, 1'b1, 3'h2, 48'h1234, 8'h00}};
    mcd_link_if link ();
    mcd_host mcd_host_inst (.clock, .resetn, .link(link.host), .cmd_go, .cmd_byte, .cmd_data,
        .cmd_ready, .done, .done_ok, .result, .result_len, .dev_status);
    mcd_device mcd_device_inst (.clock, .resetn, .link(link.dev), .meas_start, .meas_kind,
        .meas_swap, .meas_cfg, .meas_scale, .meas_done, .meas_value, .corr_start,
        .corr_sensor_raw, .corr_temp_raw, .corr_done, .corr_sensor, .corr_temp, .nvm_locked,
        .cyclic_enter);
    mcd_link_assertions mcd_link_assertions_inst (.clock, .resetn, .req_valid(link.req_valid),
        .req_cmd(link.req_cmd), .ack_valid(link.ack_valid), .ack_ok(link.ack_ok),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_len(link.rsp_len),
        .status(link.status));
    always #10 clock = ~clock;
    // Distinct value per kind so a swapped order shows in the result
    always @(posedge clock) begin
        meas_done <= #1 meas_start;
        meas_value <= #1 24'h000100 << meas_kind; // Zero samples always served
        corr_done <= #1 corr_start;
        corr_sensor <= #1 corr_sensor_raw ^ 24'hC00000;
        corr_temp <= #1 corr_temp_raw ^ 24'h400000;
        if (meas_start === 1'b1) begin
            kinds <= {kinds[5:0], meas_kind};
            cfg_seen <= meas_cfg;
            if (meas_swap !== ~meas_kind[0]) swap_bad <= 1'b1;
        end
    end
    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input mcd_row_t r);
        int i;
        for (i = 0; i < 200 && cmd_ready !== 1'b1; i++) @(posedge clock) #1;
        if (i == 200) begin
            n_errors++;
            tally_and_finish();
        end
        kinds = 8'h00;
        cmd_byte = r.cmd;
        cmd_data = r.data;
        cmd_go = 1'b1;
        @(posedge clock) #1;
        cmd_go = 1'b0;
        for (i = 0; i < 300 && done !== 1'b1; i++) @(posedge clock) #1;
        if (i == 300) begin
            n_errors++;
            tally_and_finish();
        end
        `CHK("accept", r.ok, done_ok)
        `CHK("kinds", r.kinds, kinds)
        if (r.cmd == 8'hA3) `CHK("setup", r.data, cfg_seen)
        if (r.cmd == 8'hA2) `CHK("setup", 16'h1234, cfg_seen)
        if (r.cmd == 8'hA6) `CHK("setup", 16'h0F0F, cfg_seen)
        if (r.cmd == 8'hA6) `CHK("scale", 16'h3C3C, meas_scale)
        if (r.ok) begin
            `CHK("length", r.len, result_len)
            `CHK("result", r.res, result)
        end
        $display("Test %h ended", r.cmd);
    endtask
    initial begin
        repeat (5) @(posedge clock);
        #1;
        `CHK("ready", 1'b0, cmd_ready)
        resetn = 1'b1;
        foreach (rows[k])
            run(rows[k]);
        nvm_locked = 1'b1;
        run('{8'h24, 16'hBEEF, 1'b0, 3'h0, 48'h0, 8'h00});
        nvm_locked = 1'b0;
        run('{8'h04, 16'h0, 1'b1, 3'h2, 48'h0F0F, 8'h00});
        cyclic_enter = 1'b1;
        @(posedge clock) #1;
        cyclic_enter = 1'b0;
        run('{8'h03, 16'h0, 1'b0, 3'h0, 48'h0, 8'h00});
        run('{8'h90, 16'h0, 1'b0, 3'h0, 48'h0, 8'h00});
        run('{8'hA8, 16'h0, 1'b1, 3'h0, 48'h0, 8'h00});
        repeat (2) @(posedge clock) #1;
        `CHK("status", 8'h40, dev_status)
        `CHK("swap", 1'b0, swap_bad)
        resetn = 1'b0;
        @(posedge clock) #1;
        resetn = 1'b1;
        run('{8'h03, 16'h0, 1'b1, 3'h2, 48'h0, 8'h00});
        tally_and_finish();
    end
endmodule
